// [include/cpu_regs_map.svh]
/*
  Constants of the CPU register set: flag positions, reset values,
  prefetch queue sizes. Assumes inclusion by the package only.
*/
`ifndef CPU_REGS_MAP_SVH
`define CPU_REGS_MAP_SVH

// --------------------------------------------------------------------
// Condition flag positions
// --------------------------------------------------------------------
`define FLAG_S 7
`define FLAG_X 6
`define FLAG_H 5
`define FLAG_I 4
`define FLAG_N 3
`define FLAG_Z 2
`define FLAG_V 1
`define FLAG_C 0

// --------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------
`define FLAGS_RESET 8'hD0
`define ACC_RESET  8'h00
`define WORD_RESET 16'h0000
`define WORK_RESET 20'h0_0000

// --------------------------------------------------------------------
// Prefetch queue
// --------------------------------------------------------------------
`define QUEUE_BYTES 3'h4
`define QUEUE_MIN   3'h3

`endif

// [include/cpu_regs_pkg.sv]
/*
  Types of the CPU register set: commands, register selects,
  indexed modes, sequencer states and the complete state record.
  Assumes cpu_regs_map.svh on the include path.
*/
`include "cpu_regs_map.svh"
package cpu_regs_pkg;

  typedef enum logic [3:0] {
    OP_NONE, OP_LOAD, OP_ADD, OP_ADC, OP_ASUM, OP_SUB, OP_DADJ,
    OP_EA, OP_STOP, OP_STW, OP_LDW, OP_EADD
  } op_e;

  typedef enum logic [2:0] {
    R_A, R_B, R_D, R_X, R_Y, R_SP, R_PC, R_FLAGS
  } reg_e;

  typedef enum logic [1:0] {BASE_X, BASE_Y, BASE_SP, BASE_PC} base_e;

  typedef enum logic [2:0] {
    IM_CONST, IM_ACC_A, IM_ACC_B, IM_ACC_D, IM_PRE, IM_POST
  } idx_mode_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_WHI  = 5'b0_0010,
    ST_WLO  = 5'b0_0100,
    ST_RHI  = 5'b0_1000,
    ST_RLO  = 5'b1_0000
  } seq_e;

  typedef struct packed {
    logic        valid;
    op_e         op;
    reg_e        dst;
    logic        word;
    logic [15:0] data;
  } cmd_s;

  typedef struct packed {
    base_e       base;
    idx_mode_e   mode;
    logic [15:0] offset;
  } idx_s;

  typedef struct packed {
    logic [15:0] res;
    logic        n;
    logic        z;
    logic        v;
    logic        c;
    logic        h;
  } alu_s;

  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  flags;
    logic [19:0] work;
    logic [15:0] ea;
    logic        ea_err;
    logic        stop_mode;
    logic        hpi_take;
    logic        irq_take;
    seq_e        seq;
    reg_e        mdst;
    logic [15:0] maddr;
    logic [15:0] mdata;
    logic        mem_rd;
    logic        mem_wr;
    logic [7:0]  mem_wdata;
    logic [31:0] q;
    logic [2:0]  qcnt;
    logic        fetch_ready;
    logic        insn_ready;
    logic        busy;
  } state_s;

endpackage

// [hw/cpu_register_set.sv]
/*
  Programmer-visible register set of a 16-bit CPU: accumulators,
  index registers, stack pointer, program counter, condition flags,
  20-bit working register, indexed address former, byte-serial word
  store/load and a four-byte instruction prefetch queue.
  Assumes the decoder drives one command per cycle, memory returns
  read data in the same cycle as mem_rd, all inputs synchronous to mclk.
*/
`timescale 1ns/100ps
module cpu_register_set
  import cpu_regs_pkg::*;
(
  input  logic        mclk,
  input  logic        resetn,
  input  logic        clk_en,
  input  cmd_s        cmd,
  input  idx_s        idx,
  input  logic        hpi_req_n,
  input  logic        irq_req,
  input  logic [7:0]  mem_rdata,
  input  logic        fetch_valid,
  input  logic [7:0]  fetch_byte,
  input  logic        insn_start,
  input  logic [2:0]  insn_len,
  output logic [7:0]  acc_a,
  output logic [7:0]  acc_b,
  output logic [15:0] acc_d,
  output logic [15:0] index_x,
  output logic [15:0] index_y,
  output logic [15:0] stack_ptr,
  output logic [15:0] prog_cnt,
  output logic [7:0]  cond_flags,
  output logic [19:0] work,
  output logic [15:0] eff_addr,
  output logic        eff_addr_err,
  output logic        stop_mode,
  output logic        hpi_take,
  output logic        irq_take,
  output logic        mem_rd,
  output logic        mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0]  mem_wdata,
  output logic        busy,
  output logic        fetch_ready,
  output logic        insn_ready,
  output logic [23:0] insn_bytes
);

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  function automatic logic [15:0] rd_reg(input state_s s, input reg_e r);
    logic [15:0] v;
    v = `WORD_RESET;
    unique case (r)
      R_A:   v = {8'h00, s.a};
      R_B:   v = {8'h00, s.b};
      R_D:   v = {s.a, s.b};
      R_X:   v = s.x;
      R_Y:   v = s.y;
      R_SP:  v = s.sp;
      R_PC:  v = s.pc;
      R_FLAGS: v = {8'h00, s.flags};
    endcase
    return v;
  endfunction

  function automatic state_s wr_reg(input state_s s, input reg_e r,
                                    input logic [15:0] v);
    state_s t;
    t = s;
    unique case (r)
      R_A:   t.a = v[7:0];
      R_B:   t.b = v[7:0];
      R_D:
      begin
        t.a = v[15:8];
        t.b = v[7:0];
      end
      R_X:   t.x = v;
      R_Y:   t.y = v;
      R_SP:  t.sp = v;
      R_PC:  t.pc = v;
      R_FLAGS: t.flags = v[7:0];
    endcase
    return t;
  endfunction

  // Add or subtract, byte or word; flags as seen by the result
  function automatic alu_s alu(input logic [15:0] p, input logic [15:0] q,
                               input logic cin, input logic sub,
                               input logic word);
    alu_s        o;
    logic [16:0] s;
    logic [15:0] qq;
    logic        msb_p;
    logic        msb_q;
    logic        msb_r;
    qq = sub ? ~q : q;
    s  = {1'b0, p} + {1'b0, qq} + {16'h0000, cin ^ sub};
    o  = '0;
    if (word)
    begin
      o.res = s[15:0];
      msb_p = p[15];
      msb_q = qq[15];
      msb_r = s[15];
      o.c   = s[16] ^ sub;
      o.z   = (s[15:0] == 16'h0000);
    end
    else
    begin
      o.res = {8'h00, s[7:0]};
      msb_p = p[7];
      msb_q = qq[7];
      msb_r = s[7];
      o.c   = (p[8] ^ qq[8] ^ s[8]) ^ sub;
      o.z   = (s[7:0] == 8'h00);
    end
    o.n = msb_r;
    o.v = (msb_p == msb_q) && (msb_r != msb_p);
    o.h = p[4] ^ qq[4] ^ s[4];
    return o;
  endfunction

  function automatic logic [15:0] base_val(input state_s s, input base_e b);
    logic [15:0] v;
    v = `WORD_RESET;
    unique case (b)
      BASE_X:  v = s.x;
      BASE_Y:  v = s.y;
      BASE_SP: v = s.sp;
      BASE_PC: v = s.pc;
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  state_s      r;
  state_s      n;
  alu_s        res;
  logic [15:0] opnd;
  logic [15:0] base;
  logic [15:0] moved;
  logic [7:0]  adj;
  logic        adj_c;
  logic [2:0]  cnt;
  logic        take_byte;
  logic        go;
  logic        cmd_ok;

  always_comb
  begin
    n         = r;
    res       = '0;
    opnd      = `WORD_RESET;
    base      = base_val(r, idx.base);
    moved     = `WORD_RESET;
    adj       = 8'h00;
    adj_c     = 1'b0;
    cnt       = r.qcnt;
    n.mem_rd  = 1'b0;
    n.mem_wr  = 1'b0;
    cmd_ok    = cmd.valid && (r.seq == ST_IDLE);

    // ----------------------------------------------------------------
    // Interrupt gating
    // ----------------------------------------------------------------
    n.hpi_take = !hpi_req_n && !r.flags[`FLAG_X];
    n.irq_take = irq_req && !r.flags[`FLAG_I];

    // ----------------------------------------------------------------
    // Word store and load sequencer
    // ----------------------------------------------------------------
    unique case (r.seq)
      ST_IDLE:
      begin
        if (cmd_ok && cmd.op == OP_STW)
        begin
          n.maddr     = cmd.data;
          n.mdata     = rd_reg(r, cmd.dst);
          n.mem_wr    = 1'b1;
          n.mem_wdata = n.mdata[15:8];
          n.seq       = ST_WHI;
        end
        else if (cmd_ok && cmd.op == OP_LDW)
        begin
          n.maddr  = cmd.data;
          n.mdst   = cmd.dst;
          n.mem_rd = 1'b1;
          n.seq    = ST_RHI;
        end
      end
      ST_WHI:
      begin
        n.maddr     = r.maddr + 16'h0001;
        n.mem_wr    = 1'b1;
        n.mem_wdata = r.mdata[7:0];
        n.seq       = ST_WLO;
      end
      ST_WLO:
      begin
        n.seq = ST_IDLE;
      end
      ST_RHI:
      begin
        n.mdata  = {mem_rdata, 8'h00};
        n.maddr  = r.maddr + 16'h0001;
        n.mem_rd = 1'b1;
        n.seq    = ST_RLO;
      end
      ST_RLO:
      begin
        n     = wr_reg(n, r.mdst, {r.mdata[15:8], mem_rdata});
        n.seq = ST_IDLE;
      end
      default:
      begin
        n.seq = ST_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Register and arithmetic commands
    // ----------------------------------------------------------------
    if (cmd_ok)
    begin
      unique case (cmd.op)
        OP_LOAD:
        begin
          n = wr_reg(n, cmd.dst, cmd.data);
        end
        OP_ADD, OP_ADC, OP_SUB, OP_ASUM:
        begin
          opnd = (cmd.op == OP_ASUM) ? {8'h00, r.b} : cmd.data;
          res  = alu(rd_reg(r, cmd.op == OP_ASUM ? R_A : cmd.dst), opnd,
                     (cmd.op == OP_ADC) && r.flags[`FLAG_C],
                     cmd.op == OP_SUB,
                     cmd.word && cmd.op != OP_ASUM);
          n    = wr_reg(n, cmd.op == OP_ASUM ? R_A : cmd.dst, res.res);
          n.flags[`FLAG_N] = res.n;
          n.flags[`FLAG_Z] = res.z;
          n.flags[`FLAG_V] = res.v;
          n.flags[`FLAG_C] = res.c;
          if (cmd.op != OP_SUB && !(cmd.word && cmd.op != OP_ASUM))
          begin
            n.flags[`FLAG_H] = res.h;
          end
        end
        OP_DADJ:
        begin
          adj   = 8'h00;
          adj_c = r.flags[`FLAG_C] || (r.a > 8'h99);
          if (r.flags[`FLAG_H] || (r.a[3:0] > 4'h9))
          begin
            adj = adj | 8'h06;
          end
          if (adj_c)
          begin
            adj = adj | 8'h60;
          end
          n.a              = r.a + adj;
          n.flags[`FLAG_C] = adj_c;
          n.flags[`FLAG_N] = n.a[7];
          n.flags[`FLAG_Z] = (n.a == 8'h00);
        end
        OP_EADD:
        begin
          n.work = r.work + {4'h0, r.a, r.b};
          n.flags[`FLAG_C] = n.work[16] ^ r.work[16];
        end
        OP_STOP:
        begin
          n.stop_mode = !r.flags[`FLAG_S];
        end
        OP_EA:
        begin
          n.ea_err = 1'b0;
          unique case (idx.mode)
            IM_CONST: n.ea = base + idx.offset;
            IM_ACC_A: n.ea = base + {8'h00, r.a};
            IM_ACC_B: n.ea = base + {8'h00, r.b};
            IM_ACC_D: n.ea = base + {r.a, r.b};
            IM_PRE, IM_POST:
            begin
              moved = base + idx.offset;
              n.ea  = (idx.mode == IM_PRE) ? moved : base;
              if (idx.base == BASE_PC)
              begin
                n.ea_err = 1'b1;
              end
              else
              begin
                n = wr_reg(n, idx.base == BASE_X ? R_X :
                              idx.base == BASE_Y ? R_Y : R_SP, moved);
              end
            end
            default: n.ea_err = 1'b1;
          endcase
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // Prefetch queue
    // ----------------------------------------------------------------
    go = insn_start && r.insn_ready && (insn_len != 3'd0)
         && (insn_len <= r.qcnt);
    if (go)
    begin
      n.q  = r.q << {insn_len, 3'b000};
      cnt  = r.qcnt - insn_len;
      n.pc = r.pc + {13'h0000, insn_len};
      // A stop accepted in the same cycle wins over the clear
      if (!(cmd_ok && cmd.op == OP_STOP))
      begin
        n.stop_mode = 1'b0;
      end
    end
    take_byte = fetch_valid && r.fetch_ready;
    if (take_byte)
    begin
      n.q[8 * (3 - cnt[1:0]) +: 8] = fetch_byte;
      cnt = cnt + 3'd1;
    end
    n.qcnt        = cnt;
    n.fetch_ready = (cnt < `QUEUE_BYTES);
    n.insn_ready  = (cnt >= `QUEUE_MIN);
    n.busy        = (n.seq != ST_IDLE);
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      r             <= '0;
      r.a           <= `ACC_RESET;
      r.b           <= `ACC_RESET;
      r.x           <= `WORD_RESET;
      r.y           <= `WORD_RESET;
      r.sp          <= `WORD_RESET;
      r.pc          <= `WORD_RESET;
      r.flags       <= `FLAGS_RESET;
      r.work        <= `WORK_RESET;
      r.seq         <= ST_IDLE;
      r.fetch_ready <= 1'b1;
    end
    else if (clk_en)
    begin
      r <= n;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign acc_a        = r.a;
  assign acc_b        = r.b;
  assign acc_d        = {r.a, r.b};
  assign index_x      = r.x;
  assign index_y      = r.y;
  assign stack_ptr    = r.sp;
  assign prog_cnt     = r.pc;
  assign cond_flags   = r.flags;
  assign work         = r.work;
  assign eff_addr     = r.ea;
  assign eff_addr_err = r.ea_err;
  assign stop_mode    = r.stop_mode;
  assign hpi_take     = r.hpi_take;
  assign irq_take     = r.irq_take;
  assign mem_rd       = r.mem_rd;
  assign mem_wr       = r.mem_wr;
  assign mem_addr     = r.maddr;
  assign mem_wdata    = r.mem_wdata;
  assign busy         = r.busy;
  assign fetch_ready  = r.fetch_ready;
  assign insn_ready   = r.insn_ready;
  assign insn_bytes   = r.q[31:8];

endmodule // cpu_register_set

// [sim/cpu_register_set_asserts.sv]
/*
  Port checks of the CPU register set.
  Assumes binding to cpu_register_set; one clock, mclk.
*/
`timescale 1ns/100ps
module cpu_register_set_chk
  import cpu_regs_pkg::*;
(
  input logic        mclk,
  input logic        resetn,
  input logic        clk_en,
  input cmd_s        cmd,
  input idx_s        idx,
  input logic        hpi_req_n,
  input logic        irq_req,
  input logic        insn_start,
  input logic [2:0]  insn_len,
  input logic        insn_ready,
  input logic [7:0]  acc_a,
  input logic [7:0]  acc_b,
  input logic [15:0] acc_d,
  input logic [15:0] index_x,
  input logic [15:0] prog_cnt,
  input logic [7:0]  cond_flags,
  input logic [15:0] eff_addr,
  input logic        eff_addr_err,
  input logic        stop_mode,
  input logic        hpi_take,
  input logic        irq_take,
  input logic        mem_rd,
  input logic        mem_wr,
  input logic [15:0] mem_addr,
  input logic        busy
);
  logic take;
  assign take = clk_en && cmd.valid && !busy;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_acc_d;
    acc_d == {acc_a, acc_b};
  endproperty
  a_acc_d: assert property (p_acc_d) else $error("double view mismatch");
  property p_load;
    take && cmd.op == OP_LOAD && cmd.dst == R_A |=>
      acc_a == $past(cmd.data[7:0]) && $stable(cond_flags);
  endproperty
  a_load: assert property (p_load) else $error("load wrong");
  property p_hpi;
    clk_en |=> hpi_take == ($past(!hpi_req_n) && !$past(cond_flags[6]));
  endproperty
  a_hpi: assert property (p_hpi) else $error("pin gate wrong");
  property p_irq;
    clk_en |=> irq_take == ($past(irq_req) && !$past(cond_flags[4]));
  endproperty
  a_irq: assert property (p_irq) else $error("mask gate wrong");
  property p_stop;
    take && cmd.op == OP_STOP && cond_flags[7] && !stop_mode |=> !stop_mode;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not disabled");
  property p_stw;
    take && cmd.op == OP_STW |=> mem_wr && mem_addr == $past(cmd.data)
      ##1 mem_wr && mem_addr == $past(cmd.data, 2) + 16'h0001 ##1 !busy;
  endproperty
  a_stw: assert property (p_stw) else $error("store order wrong");
  property p_ldw;
    take && cmd.op == OP_LDW |=> mem_rd && busy
      ##1 mem_rd && mem_addr == $past(cmd.data, 2) + 16'h0001 ##2 !busy;
  endproperty
  a_ldw: assert property (p_ldw) else $error("fetch order wrong");
  property p_ea_pc;
    take && cmd.op == OP_EA && idx.base == BASE_PC
      && (idx.mode == IM_PRE || idx.mode == IM_POST) |=> eff_addr_err;
  endproperty
  a_ea_pc: assert property (p_ea_pc) else $error("pc auto mode taken");
  property p_ea_x;
    take && cmd.op == OP_EA && idx.base == BASE_X && idx.mode == IM_CONST
      |=> eff_addr == $past(index_x) + $past(idx.offset) && !eff_addr_err;
  endproperty
  a_ea_x: assert property (p_ea_x) else $error("address sum wrong");
  property p_pc;
    clk_en && insn_start && insn_ready && insn_len != 3'd0 && insn_len <= 3'd3
      |=> prog_cnt == $past(prog_cnt) + $past(insn_len);
  endproperty
  a_pc: assert property (p_pc) else $error("pc step wrong");
  property p_nz;
    take && cmd.op == OP_ADD && cmd.dst == R_A && !cmd.word
      |=> cond_flags[3] == acc_a[7] && cond_flags[2] == (acc_a == 8'h00);
  endproperty
  a_nz: assert property (p_nz) else $error("n or z wrong");
endmodule // cpu_register_set_chk

bind cpu_register_set cpu_register_set_chk chk_u (.*);

// [sim/tb.sv]
/*
  Self-checking bench of the CPU register set.
  Assumes the package and the design compiled first.
*/
`timescale 1ns/100ps
module tb;
  import cpu_regs_pkg::*;
  logic        mclk, resetn, clk_en, hpi_req_n, irq_req, fetch_valid, insn_start;
  cmd_s        cmd;
  idx_s        idx;
  logic [7:0]  mem_rdata, fetch_byte, acc_a, acc_b, cond_flags, mem_wdata, a, d, f;
  logic [2:0]  insn_len;
  logic [15:0] acc_d, index_x, index_y, stack_ptr, prog_cnt, eff_addr, mem_addr, xv, dv, e16;
  logic [19:0] work;
  logic [23:0] insn_bytes;
  logic [12:0] e;
  logic        eff_addr_err, stop_mode, hpi_take, irq_take, mem_rd, mem_wr, busy;
  logic        fetch_ready, insn_ready;
  logic [7:0]  mem [logic [15:0]];
  logic [7:0]  fb [5];
  op_e         o;
  int          n_mismatch, comparisons;

  cpu_register_set dut_u (.*);

  initial
  begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end

  always @(negedge mclk)
  begin
    if (mem_wr)
      mem[mem_addr] = mem_wdata;
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string s, input logic [23:0] ex, input logic [23:0] g);
    comparisons++;
    if (g !== ex)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", s, ex, g);
    end
  endtask

  task automatic issue(input op_e op, input reg_e r, input logic w, input logic [15:0] v);
    @(posedge mclk);
    #1 cmd = '{1'b1, op, r, w, v};
    @(posedge mclk);
    #1 cmd.valid = 1'b0;
  endtask

  task automatic wt;
    for (int i = 0; i < 10 && busy !== 1'b0; i++)
      @(posedge mclk) #1;
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [12:0] alu8(input op_e op, input logic [7:0] x, input logic [7:0] y,
                                       input logic ci, input logic h0);
    logic [8:0] r;
    logic [4:0] l;
    logic       c;
    logic       v;
    c = (op == OP_ADC) & ci;
    if (op == OP_SUB)
    begin
      r = {1'b0, x} - {1'b0, y};
      v = (x[7] != y[7]) && (r[7] != x[7]);
    end
    else
    begin
      r = {1'b0, x} + {1'b0, y} + {8'h00, c};
      v = (x[7] == y[7]) && (r[7] != x[7]);
    end
    l = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, c};
    return {(op == OP_SUB) ? h0 : l[4], r[7], r[7:0] == 8'h00, v, r[8], r[7:0]};
  endfunction
  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    stop_test;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {resetn, hpi_req_n, clk_en, irq_req, fetch_valid, insn_start} = 6'b011000;
    cmd = '0;
    idx = '0;
    fetch_byte = 8'h00;
    insn_len = 3'd0;
    void'($urandom(27383));
    repeat (20) @(posedge mclk);
    #1 resetn = 1'b1;
    chk("flags", 24'(8'hD0), 24'(cond_flags));
    chk("d", 24'h00_0000, 24'(acc_d));
    chk("ready", 24'(2'b10), 24'({fetch_ready, insn_ready}));
    for (int i = 0; i < 32; i++)
    begin
      o = (i % 4 == 0) ? OP_ADD : (i % 4 == 1) ? OP_ADC : (i % 4 == 2) ? OP_SUB : OP_ASUM;
      a = (i < 4) ? 8'hFF : 8'($urandom);
      d = (i < 4) ? 8'h01 : 8'($urandom);
      f = 8'($urandom);
      issue(OP_LOAD, R_FLAGS, 1'b0, {8'h00, f});
      issue(OP_LOAD, R_A, 1'b0, {8'h00, a});
      issue(OP_LOAD, R_B, 1'b0, {8'h00, d});
      issue(o, R_A, 1'b0, {8'h00, d});
      e = alu8(o == OP_ASUM ? OP_ADD : o, a, d, f[0], f[5]);
      chk("acc_a", 24'(e[7:0]), 24'(acc_a));
      chk("hnzvc", 24'(e[12:8]), 24'({cond_flags[5], cond_flags[3:0]}));
    end
    issue(OP_LOAD, R_FLAGS, 1'b0, 16'h0000);
    issue(OP_LOAD, R_D, 1'b1, 16'h7FFF);
    issue(OP_ADD, R_D, 1'b1, 16'h0001);
    chk("word", 24'h00_8000, 24'({acc_a, acc_b}));
    chk("nzvc", 24'(4'b1010), 24'(cond_flags[3:0]));
    issue(OP_LOAD, R_A, 1'b0, 16'h0009);
    issue(OP_ADD, R_A, 1'b0, 16'h0008);
    issue(OP_DADJ, R_A, 1'b0, 16'h0000);
    chk("daa", 24'(8'h17), 24'(acc_a));
    issue(OP_LOAD, R_A, 1'b0, 16'h0099);
    issue(OP_ADD, R_A, 1'b0, 16'h0001);
    issue(OP_DADJ, R_A, 1'b0, 16'h0000);
    chk("daa_zc", 24'(10'h003), 24'({acc_a, cond_flags[2], cond_flags[0]}));
    xv = 16'($urandom);
    dv = 16'($urandom);
    issue(OP_LOAD, R_X, 1'b1, xv);
    issue(OP_LOAD, R_D, 1'b1, dv);
    issue(OP_EADD, R_D, 1'b1, 16'h0000);
    issue(OP_EADD, R_D, 1'b1, 16'h0000);
    chk("work", 24'({3'b000, dv, 1'b0}), 24'(work));
    for (int m = 0; m < 4; m++)
    begin
      e16 = 16'($urandom);
      idx = '{BASE_X, idx_mode_e'(m), e16};
      issue(OP_EA, R_A, 1'b0, 16'h0000);
      e16 = xv + (m == 0 ? e16 : m == 1 ? {8'h00, dv[15:8]} : m == 2 ? {8'h00, dv[7:0]} : dv);
      chk("eff_addr", 24'(e16), 24'(eff_addr));
    end
    idx = '{BASE_SP, IM_POST, e16};
    issue(OP_EA, R_A, 1'b0, 16'h0000);
    chk("sp_ea", 24'h00_0000, 24'(eff_addr));
    chk("stack_ptr", 24'(e16), 24'(stack_ptr));
    for (int i = 0; i < 3; i++)
    begin
      idx = '{i == 2 ? BASE_X : BASE_PC, i == 1 ? IM_POST : IM_PRE, 16'h0001};
      issue(OP_EA, R_A, 1'b0, 16'h0000);
      chk("ea_err", 24'(i != 2), 24'(eff_addr_err));
    end
    issue(OP_LOAD, R_X, 1'b1, xv);
    issue(OP_STW, R_X, 1'b1, 16'h0101);
    wt();
    chk("mem", 24'(xv), 24'({mem[16'h0101], mem[16'h0102]}));
    issue(OP_LDW, R_Y, 1'b1, 16'h0101);
    wt();
    chk("index_y", 24'(xv), 24'(index_y));
    for (int s = 1; s >= 0; s--)
    begin
      issue(OP_LOAD, R_FLAGS, 1'b0, {8'h00, s[0], 7'h00});
      issue(OP_STOP, R_A, 1'b0, 16'h0000);
      chk("stop_mode", 24'(!s[0]), 24'(stop_mode));
    end
    for (int k = 0; k < 4; k++)
    begin
      issue(OP_LOAD, R_FLAGS, 1'b0, {8'h00, 1'b0, k[1], 1'b0, k[0], 4'h0});
      hpi_req_n = 1'b0;
      irq_req = 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk("takes", 24'({!k[1], !k[0]}), 24'({hpi_take, irq_take}));
      hpi_req_n = 1'b1;
      irq_req = 1'b0;
    end
    clk_en = 1'b0;
    a = acc_a;
    issue(OP_LOAD, R_A, 1'b0, {8'h00, ~a});
    chk("frozen", 24'(a), 24'(acc_a));
    clk_en = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      fb[i] = 8'($urandom);
      fetch_byte = fb[i];
      fetch_valid = 1'b1;
      @(posedge mclk) #1;
    end
    fetch_valid = 1'b0;
    chk("queue", {fb[0], fb[1], fb[2]}, insn_bytes);
    chk("full", 24'(2'b01), 24'({fetch_ready, insn_ready}));
    e16 = 16'h0003;
    insn_start = 1'b1;
    insn_len = 3'd3;
    @(posedge mclk) #1 insn_start = 1'b0;
    chk("prog_cnt", 24'(e16), 24'(prog_cnt));
    chk("after", 24'({fb[3], 3'b010}),
        24'({insn_bytes[23:16], stop_mode, fetch_ready, insn_ready}));
    stop_test;
  end
endmodule // tb
